// ---- core/pllpd_ctrl.v ----
/*
 * Clock ratio selection and power-down controller with a Wishbone slave.
 * Assumes the ratio straps come from board pins and are asynchronous, that
 * the PLL analog macro sits outside and reports lock, and that wake events
 * arrive as levels from the interrupt controller in the core clock domain.
 */
// Our own choices: the register addresses and the Wishbone interface to the registers.
// Overview of operation
// R1: Strap 01 selects multiply by six, 10 by twelve, 11 is reserved.
// R2: Undriven straps read 00 and select bypass at ratio one.
// R3: Lock wait allows 150 percent beyond the 75 us typical; none in bypass.
// R4: Sleep mode and wake method come from control register bits 15 to 10.
// R5: Software should write all six sleep bits in one write.
// R6: Software should write zero to the reserved top sleep bit.
// R7: Gating acts on the reference clock path, the PLL output and the CPU clock.
// R8: Field decodes run, two light sleeps, clock stop, oscillator stop.
// R9: Clock stop and oscillator stop end only through device reset.
// R10: Selected mode takes effect up to nine cycles after the write.
// R11: Core clock is either PLL output or the reference passed through.
// R12: Two output clocks at a quarter and a sixth of core frequency.
`default_nettype none
`include "pllpd_regs.vh"

module pllpd_ctrl #(
    parameter integer LOCK_CYCLES = ((`PLLPD_LOCK_TYP_US * (100 + `PLLPD_LOCK_MARGIN_PCT)
                                     * `PLLPD_CLK_MHZ) + 99) / 100
) (
    input  wire        core_clk,
    input  wire        rst_b,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output wire        wb_err_o,
    input  wire        ratio_select_high,
    input  wire        ratio_select_low,
    input  wire        pll_locked,
    input  wire        irq_enabled,
    input  wire        irq_any,
    output reg         pll_bypass_q,
    output reg  [1:0]  pll_ratio_q,
    output reg         pll_enable_q,
    output reg         ref_gate_en_q,
    output reg         pll_out_gate_en_q,
    output reg         cpu_clk_en_q,
    output reg         ratio_reserved_q,
    output wire        core_div4_output,
    output wire        core_div6_output
);
    // ****************************************************************
    // State codes
    // ****************************************************************
    localparam [2:0] ST_STRAP   = 3'h0;
    localparam [2:0] ST_LOCK    = 3'h1;
    localparam [2:0] ST_RUN     = 3'h2;
    localparam [2:0] ST_PEND    = 3'h3;
    localparam [2:0] ST_LIGHT   = 3'h4;
    localparam [2:0] ST_CLKSTOP = 3'h5;
    localparam [2:0] ST_OSCSTOP = 3'h6;

    // Is the sleep code one of the four documented sleep modes (run excluded).
    function valid_mode;
        input [5:0] m;
        begin
            valid_mode = (m == `PLLPD_SLP_LIGHT_EN) || (m == `PLLPD_SLP_LIGHT_ANY) ||
                         (m == `PLLPD_SLP_CLKSTOP) || (m == `PLLPD_SLP_OSCSTOP);
        end
    endfunction

    // Is the sleep code a deep mode that only reset leaves.
    function is_deep;
        input [5:0] m;
        begin
            is_deep = (m == `PLLPD_SLP_CLKSTOP) || (m == `PLLPD_SLP_OSCSTOP);
        end
    endfunction

    // ****************************************************************
    // Strap synchronisers
    // ****************************************************************
    reg [1:0] strap_meta_q;
    reg [1:0] strap_sync_q;

    // Two stages before any logic looks at the board straps. They have no reset, so the
    // straps settle through both stages while reset is held and are valid at release.
    always @(posedge core_clk) begin
        strap_meta_q <= {ratio_select_high, ratio_select_low};
        strap_sync_q <= strap_meta_q;
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    reg  [31:0] csr_q;
    reg  [2:0]  state_q;
    reg  [2:0]  state_d;
    reg  [31:0] lock_cnt_q;
    reg  [3:0]  entry_cnt_q;
    reg  [5:0]  active_mode_q;
    wire [5:0]  sleep_select_field = csr_q[`PLLPD_SLP_HI:`PLLPD_SLP_LO];
    wire        req       = wb_cyc_i & wb_stb_i;
    wire        hit_csr   = (wb_adr_i == `PLLPD_CSR_ADDR);
    wire        hit_stat  = (wb_adr_i == `PLLPD_STAT_ADDR);
    wire        csr_wr    = req & ~wb_ack_o & wb_we_i & hit_csr;
    wire        light_sleep            = (state_q == ST_LIGHT);
    wire        clock_stop_sleep       = (state_q == ST_CLKSTOP);
    wire        oscillator_stop_sleep  = (state_q == ST_OSCSTOP);
    wire        lock_done = (lock_cnt_q >= LOCK_CYCLES - 1);

    // Ack one cycle after the request; unmapped addresses answer with an error.
    assign wb_err_o = wb_ack_o & ~(hit_csr | hit_stat);

    // Bus slave: byte lane writes into the control register, registered reads.
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            csr_q    <= `PLLPD_CSR_RESET;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
            if (csr_wr) begin
                if (wb_sel_i[0]) csr_q[7:0]   <= wb_dat_i[7:0];
                if (wb_sel_i[1]) csr_q[15:8]  <= wb_dat_i[15:8];   // see R4
                if (wb_sel_i[2]) csr_q[23:16] <= wb_dat_i[23:16];
                if (wb_sel_i[3]) csr_q[31:24] <= wb_dat_i[31:24];
            end else if (state_q == ST_LIGHT && state_d == ST_RUN) begin
                csr_q[`PLLPD_SLP_HI:`PLLPD_SLP_LO] <= `PLLPD_SLP_RUN;
            end
            if (req & ~wb_ack_o & ~wb_we_i) begin
                if (hit_csr)
                    wb_dat_o <= csr_q;
                else if (hit_stat)
                    wb_dat_o <= {19'h0, active_mode_q, pll_ratio_q, ratio_reserved_q,
                                 pll_locked, state_q};
                else
                    wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    // ****************************************************************
    // Mode sequencer
    // ****************************************************************
    // Chooses next state from straps, lock, pending sleep requests and wakes.
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_STRAP: begin
                if (strap_sync_q == `PLLPD_RATIO_BYPASS)
                    state_d = ST_RUN;                               // see R2
                else
                    state_d = ST_LOCK;                              // see R3
            end
            ST_LOCK: begin
                if (pll_locked | lock_done)
                    state_d = ST_RUN;                               // see R3
            end
            ST_RUN: begin
                if (valid_mode(sleep_select_field))
                    state_d = ST_PEND;
            end
            ST_PEND: begin
                if (entry_cnt_q == `PLLPD_ENTRY_DELAY - 4'h2) begin  // see R10
                    if (active_mode_q == `PLLPD_SLP_CLKSTOP)
                        state_d = ST_CLKSTOP;
                    else if (active_mode_q == `PLLPD_SLP_OSCSTOP)
                        state_d = ST_OSCSTOP;
                    else
                        state_d = ST_LIGHT;
                end
            end
            ST_LIGHT: begin
                if (irq_enabled ||
                    (active_mode_q == `PLLPD_SLP_LIGHT_ANY && irq_any))
                    state_d = ST_RUN;                               // see R8
            end
            ST_CLKSTOP: state_d = ST_CLKSTOP;                       // see R9
            ST_OSCSTOP: state_d = ST_OSCSTOP;                       // see R9
            default:    state_d = ST_STRAP;
        endcase
    end

    // State, lock timer, entry delay and latched mode.
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q       <= ST_STRAP;
            lock_cnt_q    <= 32'h0;
            entry_cnt_q   <= 4'h0;
            active_mode_q <= `PLLPD_SLP_RUN;
        end else begin
            state_q <= state_d;
            if (state_q == ST_LOCK)
                lock_cnt_q <= lock_cnt_q + 32'h1;
            else
                lock_cnt_q <= 32'h0;
            if (state_q == ST_PEND)
                entry_cnt_q <= entry_cnt_q + 4'h1;
            else
                entry_cnt_q <= 4'h0;
            if (state_q == ST_RUN && state_d == ST_PEND)
                active_mode_q <= sleep_select_field;                // see R8
            else if (state_q == ST_LIGHT && state_d == ST_RUN)
                active_mode_q <= `PLLPD_SLP_RUN;
        end
    end

    // ****************************************************************
    // Ratio capture and clock gating
    // ****************************************************************
    // Straps are caught once, after reset release, then held.
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pll_ratio_q      <= `PLLPD_RATIO_BYPASS;
            pll_bypass_q     <= 1'b1;
            ratio_reserved_q <= 1'b0;
        end else if (state_q == ST_STRAP) begin
            pll_ratio_q      <= strap_sync_q;                       // see R1
            pll_bypass_q     <= (strap_sync_q == `PLLPD_RATIO_BYPASS);  // see R11
            ratio_reserved_q <= (strap_sync_q == `PLLPD_RATIO_RSVD);  // see R1
        end
    end

    // Gates only the reference path, the PLL output and the CPU clock.
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ref_gate_en_q     <= 1'b1;
            pll_out_gate_en_q <= 1'b1;
            pll_enable_q      <= 1'b0;
            cpu_clk_en_q      <= 1'b0;
        end else begin
            ref_gate_en_q     <= ~oscillator_stop_sleep;            // see R7
            pll_out_gate_en_q <= ~(clock_stop_sleep | oscillator_stop_sleep);
            pll_enable_q      <= ~pll_bypass_q & ~oscillator_stop_sleep;  // see R11
            cpu_clk_en_q      <= (state_q == ST_RUN) || (state_q == ST_PEND);
        end
    end

    // ****************************************************************
    // Derived output clocks
    // ****************************************************************
    wire div_run = ~(clock_stop_sleep | oscillator_stop_sleep) & ~light_sleep |
                   light_sleep;

    // Quarter rate output.
    pllpd_divider #(.DIV(`PLLPD_DIV4)) u_div4 (                     // see R12
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .run       (div_run & ~(clock_stop_sleep | oscillator_stop_sleep)),
        .clk_out_q (core_div4_output)
    );

    // Sixth rate output.
    pllpd_divider #(.DIV(`PLLPD_DIV6)) u_div6 (                     // see R12
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .run       (div_run & ~(clock_stop_sleep | oscillator_stop_sleep)),
        .clk_out_q (core_div6_output)
    );
endmodule // pllpd_ctrl

`default_nettype wire

// ---- core/pllpd_divider.v ----
/*
 * Even integer clock divider producing a registered enable-style square wave.
 * Assumes a single free running clock and asynchronous active low reset.
 */
`default_nettype none

// ****************************************************************
// Divider
// ****************************************************************
module pllpd_divider #(
    parameter [2:0] DIV = 3'h4
) (
    input  wire       core_clk,
    input  wire       rst_b,
    input  wire       run,
    output reg        clk_out_q
);
    reg [2:0] cnt_q;

    // Counts core cycles and toggles the output at each half period.
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q     <= 3'h0;
            clk_out_q <= 1'b0;
        end else if (run) begin
            if (cnt_q == (DIV >> 1) - 3'h1) begin
                cnt_q     <= 3'h0;
                clk_out_q <= ~clk_out_q;
            end else begin
                cnt_q <= cnt_q + 3'h1;
            end
        end
    end
endmodule // pllpd_divider

`default_nettype wire

// ---- core/pllpd_regs.vh ----
/*
 * Constants for the clock ratio and power-down controller: register offsets,
 * field positions, mode codes and timing figures.
 * Assumes inclusion by bare name from the controller sources.
 */
`ifndef PLLPD_REGS_VH
`define PLLPD_REGS_VH

// ****************************************************************
// Register map (byte addresses on the Wishbone bus)
// ****************************************************************
`define PLLPD_CSR_ADDR      4'h0
`define PLLPD_STAT_ADDR     4'h4
`define PLLPD_CSR_RESET     32'h0000_0000

// ****************************************************************
// Sleep select field
// ****************************************************************
`define PLLPD_SLP_HI        15
`define PLLPD_SLP_LO        10
`define PLLPD_SLP_RUN       6'h00
`define PLLPD_SLP_LIGHT_EN  6'h09
`define PLLPD_SLP_LIGHT_ANY 6'h11
`define PLLPD_SLP_CLKSTOP   6'h1a
`define PLLPD_SLP_OSCSTOP   6'h1c

// ****************************************************************
// Ratio select codes
// ****************************************************************
`define PLLPD_RATIO_BYPASS  2'h0
`define PLLPD_RATIO_X6      2'h1
`define PLLPD_RATIO_X12     2'h2
`define PLLPD_RATIO_RSVD    2'h3

// ****************************************************************
// Timing
// ****************************************************************
`define PLLPD_LOCK_TYP_US   75
`define PLLPD_LOCK_MARGIN_PCT 150
`define PLLPD_CLK_MHZ       25
`define PLLPD_ENTRY_DELAY   4'h9
`define PLLPD_DIV4          3'h4
`define PLLPD_DIV6          3'h6

`endif

// ---- test/pllpd_ctrl_tb.sv ----
/* Self-checking bench for pllpd_ctrl, registers over classic Wishbone.
   Assumes the board model pllpd_partner and the bound checker. */
`default_nettype none
`include "pllpd_regs.vh"
// ****************************************
// Bench
// ****************************************
module pllpd_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk = 1'b0, rst_b = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0, irq_enabled = 1'b0, irq_any = 1'b0, strap_drive = 1'b0;
    logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic [1:0]  strap_code = 2'h0, pll_ratio_q;
    logic [7:0]  lock_dly = 8'h04;
    logic        wb_ack_o, wb_err_o, ratio_select_high, ratio_select_low, pll_locked;
    logic        pll_bypass_q, pll_enable_q, ref_gate_en_q, pll_out_gate_en_q, cpu_clk_en_q;
    logic        ratio_reserved_q, core_div4_output, core_div6_output;
    logic [5:0]  mode_tab [4] = '{6'h09, 6'h11, 6'h1a, 6'h1c};
    int          miscompares = 0, checks_done = 0;
    pllpd_ctrl #(.LOCK_CYCLES(20)) pllpd_ctrl_i (.*);
    pllpd_partner pllpd_partner_i (.*);
    // Free running core clock.
    always #20 core_clk = ~core_clk;
    // Prints the counts and the verdict, then ends the run.
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One classic cycle; holds the request until ack is sampled high.
    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat,
                      output logic [31:0] rd, output logic er);
        int n;
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            miscompares++;
            test_done;
        end
        rd = wb_dat_o;
        er = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    // Waits, bounded, until the CPU clock enable reaches a level.
    task automatic wait_en(input logic lvl, input int lim, output int n);
        n = 0;
        while (cpu_clk_en_q !== lvl && n < lim) begin
            @(posedge core_clk);
            n++;
        end
        if (cpu_clk_en_q !== lvl) begin
            miscompares++;
            test_done;
        end
    endtask
    // Expected {reference gate, multiplier output gate} in a sleep mode.
    function automatic logic [31:0] gates(input logic [5:0] m);
        return (m == 6'h1c) ? 32'h0 : (m == 6'h1a) ? 32'h2 : 32'h3;
    endfunction
    // Each test: strap pattern, reset, lock, dividers, bus, one sleep mode.
    initial begin
        logic [31:0] rd;
        logic        er, p4, p6;
        logic [5:0]  md;
        int          n, lk, c4, c6;
        rd = $urandom(32'h63df);
        for (int i = 0; i < 4; i++) begin
            lk = $urandom_range(40, 4);
            strap_drive <= (i != 0);
            strap_code  <= i[1:0];
            lock_dly    <= 8'(lk);
            irq_enabled <= 1'b0;
            irq_any     <= 1'b0;
            rst_b       <= 1'b0;
            repeat (3) @(posedge core_clk);
            rst_b <= 1'b1;
            wb(1'b0, `PLLPD_CSR_ADDR, 32'h0, rd, er);
            chk(rd, `PLLPD_CSR_RESET);
            wait_en(1'b1, 100, n);
            if (i != 0) chk(n + 3 >= ((lk < 20) ? lk : 20), 1);
            wb(1'b0, `PLLPD_STAT_ADDR, 32'h0, rd, er);
            chk({rd[6:5], rd[4], rd[2:0]}, {i[1:0], i == 3, 3'h2});
            chk({pll_bypass_q, pll_enable_q}, {i == 0, i != 0});
            p4 = core_div4_output;
            p6 = core_div6_output;
            c4 = 0;
            c6 = 0;
            repeat (24) begin
                @(posedge core_clk);
                c4 += int'(core_div4_output !== p4);
                c6 += int'(core_div6_output !== p6);
                p4 = core_div4_output;
                p6 = core_div6_output;
            end
            chk(c4, 12);
            chk(c6, 8);
            wb(1'b0, 4'h8 + 4'(i), 32'h0, rd, er);
            chk(rd, 32'h0);
            chk(er, 1'b1);
            do md = 6'($urandom) & 6'h1f;
            while (md inside {6'h09, 6'h11, 6'h1a, 6'h1c});
            wb(1'b1, `PLLPD_CSR_ADDR, {16'h0, md, 10'($urandom)}, rd, er);
            repeat (12) @(posedge core_clk);
            chk(cpu_clk_en_q, 1'b1);
            md = mode_tab[i];
            wb(1'b1, `PLLPD_CSR_ADDR, {16'h0, md, 10'h0}, rd, er);
            wait_en(1'b0, 11, n);
            chk({ref_gate_en_q, pll_out_gate_en_q}, gates(md));
            irq_any <= 1'b1;
            repeat (8) @(posedge core_clk);
            chk(cpu_clk_en_q, md == 6'h11);
            irq_enabled <= 1'b1;
            repeat (8) @(posedge core_clk);
            chk(cpu_clk_en_q, md[0]);
            if (md[0]) begin
                wb(1'b0, `PLLPD_CSR_ADDR, 32'h0, rd, er);
                chk(rd[15:10], 6'h00);
            end
            $display("test %0d done", i);
        end
        test_done;
    end
endmodule // pllpd_ctrl_tb
`default_nettype wire

// ---- test/pllpd_monitor.sv ----
/* Checker for pllpd_ctrl: bus answers, strap decode, sleep gating.
   Assumes it is bound into pllpd_ctrl and sees only its ports. */
`default_nettype none
// ****************************************
// Checker
// ****************************************
module pllpd_monitor #(
    parameter int LOCK_CYCLES = 20
) (
    input wire logic        core_clk,
    input wire logic        rst_b,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic        pll_bypass_q,
    input wire logic [1:0]  pll_ratio_q,
    input wire logic        pll_enable_q,
    input wire logic        ref_gate_en_q,
    input wire logic        pll_out_gate_en_q,
    input wire logic        cpu_clk_en_q,
    input wire logic        ratio_reserved_q,
    input wire logic        core_div4_output,
    input wire logic        core_div6_output
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] wait_cnt_q;
    logic        ran_q;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // Counts cycles from reset release until the core first runs.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_cnt_q <= 16'h0000;
            ran_q      <= 1'b0;
        end else begin
            ran_q <= ran_q | cpu_clk_en_q;
            if (!ran_q) wait_cnt_q <= wait_cnt_q + 16'h0001;
        end
    end
    // A taken request is answered on the next edge for one cycle.
    chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer is not a single pulse after the request");
    chk_err_decode: assert property (wb_err_o == (wb_ack_o && wb_adr_i != 4'h0 && wb_adr_i != 4'h4))
        else $error("error answer does not match the address map");
    chk_bypass_strap: assert property (pll_bypass_q == (pll_ratio_q == 2'h0))
        else $error("bypass does not follow the strap pattern");
    chk_bypass_pll_off: assert property (pll_bypass_q |-> !pll_enable_q)
        else $error("multiplier runs while bypassed");
    chk_strap_reserved: assert property (ratio_reserved_q == (pll_ratio_q == 2'h3))
        else $error("reserved strap flag wrong");
    chk_osc_stop_all: assert property (!ref_gate_en_q |-> !pll_out_gate_en_q && !cpu_clk_en_q)
        else $error("reference gated while later clocks still run");
    chk_deep_held: assert property (!pll_out_gate_en_q |=> !pll_out_gate_en_q && $stable(ref_gate_en_q))
        else $error("deep sleep left without reset");
    chk_entry_delay: assert property (wb_ack_o && wb_we_i && wb_adr_i == 4'h0
        && wb_dat_i[15:10] == 6'h1a && cpu_clk_en_q |-> ##[1:11] !pll_out_gate_en_q)
        else $error("clock stop not taken within the entry delay");
    chk_div_stop: assert property (!pll_out_gate_en_q [*3] |->
        $stable(core_div4_output) && $stable(core_div6_output))
        else $error("divided clocks run in deep sleep");
    chk_lock_bound: assert property (wait_cnt_q <= 16'(LOCK_CYCLES + 8))
        else $error("lock wait runs past its limit");
endmodule // pllpd_monitor

bind pllpd_ctrl pllpd_monitor #(.LOCK_CYCLES(LOCK_CYCLES)) pllpd_monitor_i (.*);
`default_nettype wire

// ---- test/pllpd_partner.sv ----
/* Board model for pllpd_ctrl: strap resistors and multiplier lock.
   Assumes the bench picks the strap pattern and the lock delay. */
`default_nettype none
// ****************************************
// Board model
// ****************************************
module pllpd_partner (
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    input  wire logic       strap_drive,
    input  wire logic [1:0] strap_code,
    input  wire logic [7:0] lock_dly,
    output logic            ratio_select_high,
    output logic            ratio_select_low,
    output logic            pll_locked
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] lock_cnt_q;
    // Pull-ups set the pattern; undriven pins fall to 00 via pull-downs.
    assign {ratio_select_high, ratio_select_low} = strap_drive ? strap_code : 2'b00;
    // Lock comes a set time after reset, prompt or slow; never in bypass.
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) lock_cnt_q <= 8'h00;
        else if (lock_cnt_q != 8'hff) lock_cnt_q <= lock_cnt_q + 8'h01;
    end
    assign pll_locked = (strap_code != 2'h0) && strap_drive && lock_cnt_q >= lock_dly;
endmodule // pllpd_partner
`default_nettype wire
